// *** logic/fsp_pkg.sv ***
// Constants for the flash self-programming controller.
// Assumes an SFR bus from the core with 8-bit address and data.
//
// What this block does
// - After reset, self-programming stays off until software sets enable.
// - Bit 2 of system control enables self-programming operations.
// - Target address comes from address-high (15:8) and address-low (7:0).
// - Program data byte comes from the flash data register.
// - Writing 1 to control bit 7 launches the operation in bits 1:0.
// - Function 00 program, 01 read protect, 10 page erase, 11 array erase.
// - Start is read-only until 55h, AAh, 55h are written to data register.
// - At start, address and data are sampled and the core is stalled.
// - On completion the start bit clears and the core resumes.
// - Byte program writes data register value to the addressed location.
// - Page erase clears 512 bytes; pages in the boot-loader region refused.
// - Page erase ignores bit 0 of the address-high byte.
// - Array erase clears everything except the boot-loader region.
// - Array erase also clears read protection.
// - While read protection is active, flash reads return 00h.
// - Watchdog reset sets bit 7 of system control.
package fsp_pkg;
    // ==========================================================
    // Register addresses
    localparam logic [7:0] FSP_ADDR_SYSCTL = 8'hBF;
    localparam logic [7:0] FSP_ADDR_FAH    = 8'hF4;
    localparam logic [7:0] FSP_ADDR_FAL    = 8'hF5;
    localparam logic [7:0] FSP_ADDR_FDATA  = 8'hF6;
    localparam logic [7:0] FSP_ADDR_FCTRL  = 8'hF7;
    // ==========================================================
    // Field positions and reset values
    localparam int         FSP_BIT_WDR     = 7;
    localparam int         FSP_BIT_ENABLE  = 2;
    localparam int         FSP_BIT_XRAM    = 1;
    localparam int         FSP_BIT_LATCH_STROBE_INHIBIT    = 0;
    localparam int         FSP_BIT_START   = 7;
    localparam logic [7:0] FSP_SYSCTL_RST  = 8'h0A;
    localparam logic [7:0] FSP_REG_RST     = 8'h00;
    localparam logic [7:0] FSP_UNLOCK_A    = 8'h55;
    localparam logic [7:0] FSP_UNLOCK_B    = 8'hAA;
    localparam logic [7:0] FSP_ERASED      = 8'hFF;
    localparam logic [7:0] FSP_PROT_READ   = 8'h00;
    // ==========================================================
    // Default cycle counts per operation
    localparam int         FSP_CYC_PROG    = 16;
    localparam int         FSP_CYC_PROT    = 8;
    localparam int         FSP_CYC_PAGE    = 512;
    localparam int         FSP_CYC_CHIP    = 65536;

    typedef enum logic [1:0] {
        FSP_FN_PROG  = 2'h0,
        FSP_FN_PROT  = 2'h1,
        FSP_FN_PAGE  = 2'h2,
        FSP_FN_CHIP  = 2'h3
    } fsp_fn_t;

    typedef enum logic [1:0] {
        FSP_UL_IDLE,
        FSP_UL_GOT55,
        FSP_UL_GOTAA,
        FSP_UL_ARMED
    } fsp_ul_t;
endpackage : fsp_pkg

// *** logic/fsp_flash_mem.sv ***
// Flash array model: one write port, one registered read port.
// Assumes the controller never writes and reads the same word at once.
`timescale 1ns/1ps
module fsp_flash_mem #(
    parameter int AW = 16
) (
    input  wire logic          clock_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [7:0]    wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [7:0]    rdata_o
);
    logic [7:0] mem_q [0:(1<<AW)-1];

    always_ff @(posedge clock_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clock_i) begin
        rdata_o <= mem_q[raddr_i];
    end
endmodule : fsp_flash_mem

// *** logic/fsp_ctrl.sv ***
// Flash self-programming controller with its SFR slave and flash array.
// Assumes one-cycle SFR write/read strobes from the core, same clock.
`timescale 1ns/1ps
module fsp_ctrl
    import fsp_pkg::*;
#(
    parameter int PROG_CYCLES = FSP_CYC_PROG,
    parameter int PROT_CYCLES = FSP_CYC_PROT,
    parameter int PAGE_CYCLES = FSP_CYC_PAGE,
    parameter int CHIP_CYCLES = FSP_CYC_CHIP,
    parameter int BOOT_PAGES  = 1
) (
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic        wdog_reset_i,
    input  wire logic        sfr_wr_i,
    input  wire logic        sfr_rd_i,
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic      [7:0]  sfr_rdata_o,
    output logic             sfr_hit_o,
    input  wire logic [15:0] fetch_addr_i,
    output logic      [7:0]  fetch_data_o,
    output logic             core_stall_o,
    output logic             read_protect_o
);
    localparam int NPAGES = 128;
    localparam int CW     = 17;

    if (BOOT_PAGES < 0 || BOOT_PAGES > 8 || CHIP_CYCLES < 65536
        || PROG_CYCLES < 1 || PROT_CYCLES < 1 || PAGE_CYCLES < 512
        || CHIP_CYCLES >= (1 << CW) || PAGE_CYCLES >= (1 << CW)) begin : g_bad
        $error("fsp_ctrl: unsupported parameter values");
    end

    // ==========================================================
    // Registers
    logic [7:0]  sysctl_q;
    logic [7:0]  fah_q;
    logic [7:0]  fal_q;
    logic [7:0]  fdata_q;
    logic [1:0]  fsel_q;
    logic        start_q;
    logic        prot_q;
    fsp_ul_t     ul_q;
    logic        wdr_seen_q;

    logic wr_sys, wr_fah, wr_fal, wr_dat, wr_ctl, launch, done;
    assign wr_sys = sfr_wr_i && sfr_addr_i == FSP_ADDR_SYSCTL;
    assign wr_fah = sfr_wr_i && sfr_addr_i == FSP_ADDR_FAH;
    assign wr_fal = sfr_wr_i && sfr_addr_i == FSP_ADDR_FAL;
    assign wr_dat = sfr_wr_i && sfr_addr_i == FSP_ADDR_FDATA;
    assign wr_ctl = sfr_wr_i && sfr_addr_i == FSP_ADDR_FCTRL;
    // Start taken only with fresh unlock and enable set, and only idle
    assign launch = wr_ctl && sfr_wdata_i[FSP_BIT_START] && !start_q
        && ul_q == FSP_UL_ARMED
        && sysctl_q[FSP_BIT_ENABLE];

    // Watchdog reset flag; cleared by software writing 0 to bit 7
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            sysctl_q <= FSP_SYSCTL_RST & ~(8'h01 << FSP_BIT_ENABLE);
        end else begin
            if (wr_sys) begin
                sysctl_q <= sfr_wdata_i & 8'h87;
            end
            if (wdog_reset_i) begin
                sysctl_q[FSP_BIT_WDR] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            fah_q   <= FSP_REG_RST;
            fal_q   <= FSP_REG_RST;
            fdata_q <= FSP_REG_RST;
            fsel_q  <= 2'h0;
        end else begin
            if (wr_fah) fah_q <= sfr_wdata_i;
            if (wr_fal) fal_q <= sfr_wdata_i;
            if (wr_dat) fdata_q <= sfr_wdata_i;
            if (wr_ctl && !start_q) fsel_q <= sfr_wdata_i[1:0];
        end
    end

    // ==========================================================
    // Unlock tracker
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            ul_q <= FSP_UL_IDLE;
        end else if (launch) begin
            ul_q <= FSP_UL_IDLE;
        end else if (wr_dat) begin
            unique case (ul_q)
                FSP_UL_IDLE:  ul_q <= (sfr_wdata_i == FSP_UNLOCK_A)
                                      ? FSP_UL_GOT55 : FSP_UL_IDLE;
                FSP_UL_GOT55: ul_q <= (sfr_wdata_i == FSP_UNLOCK_B)
                                      ? FSP_UL_GOTAA
                                      : (sfr_wdata_i == FSP_UNLOCK_A)
                                      ? FSP_UL_GOT55 : FSP_UL_IDLE;
                FSP_UL_GOTAA: ul_q <= (sfr_wdata_i == FSP_UNLOCK_A)
                                      ? FSP_UL_ARMED : FSP_UL_IDLE;
                // Armed stays armed so the final data byte can be loaded
                FSP_UL_ARMED: ul_q <= FSP_UL_ARMED;
            endcase
        end
    end

    // ==========================================================
    // Operation sequencer
    logic [15:0]   op_addr_q;
    logic [7:0]    op_data_q;
    logic [CW-1:0] cnt_q;
    logic [15:0]   wptr_q;
    logic          erase_q;
    logic          page_ok;
    logic [6:0]    page_idx;

    // Page index drops bit 0 of the high byte
    assign page_idx = fah_q[7:1];
    // Boot region is the top BOOT_PAGES pages
    assign page_ok  = 32'(page_idx) < NPAGES - BOOT_PAGES;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            start_q   <= 1'b0;
            op_addr_q <= 16'h0000;
            op_data_q <= 8'h00;
            cnt_q     <= '0;
            erase_q   <= 1'b0;
        end else if (launch) begin
            start_q   <= 1'b1;
            op_addr_q <= {fah_q, fal_q};
            op_data_q <= fdata_q;
            erase_q   <= 1'b0;
            unique case (fsp_fn_t'(sfr_wdata_i[1:0]))
                FSP_FN_PROG: cnt_q <= CW'(PROG_CYCLES);
                FSP_FN_PROT: cnt_q <= CW'(PROT_CYCLES);
                FSP_FN_PAGE: begin
                    cnt_q     <= CW'(PAGE_CYCLES);
                    op_addr_q <= {page_idx, 9'h000};
                    erase_q   <= page_ok;
                end
                FSP_FN_CHIP: begin
                    cnt_q     <= CW'(CHIP_CYCLES);
                    op_addr_q <= 16'h0000;
                    erase_q   <= 1'b1;
                end
            endcase
        end else if (start_q) begin
            if (cnt_q == CW'(1)) begin
                start_q <= 1'b0;
                erase_q <= 1'b0;
            end
            cnt_q <= cnt_q - CW'(1);
        end
    end

    // Erase pointer advances one byte per cycle until the operation ends; writes stop past the span
    logic [15:0] erase_end;
    assign erase_end = (fsel_q == FSP_FN_CHIP)
        ? 16'((NPAGES - BOOT_PAGES) * 512 - 1)
        : op_addr_q | 16'h01FF;

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            wptr_q <= 16'h0000;
        end else if (launch) begin
            wptr_q <= 16'h0000;
        end else if (erase_q && start_q) begin
            wptr_q <= wptr_q + 16'h0001;
        end
    end

    logic        mem_we;
    logic [15:0] mem_waddr;
    logic [7:0]  mem_wdata;
    logic [15:0] erase_addr;
    logic        erase_on;
    assign erase_addr = op_addr_q + wptr_q;
    assign erase_on   = erase_q && start_q && erase_addr <= erase_end
                        && wptr_q <= 16'((NPAGES - BOOT_PAGES) * 512 - 1);
    assign mem_we    = erase_on
        || (start_q && fsel_q == FSP_FN_PROG && cnt_q == CW'(1));
    assign mem_waddr = erase_on ? erase_addr : op_addr_q;
    assign mem_wdata = erase_on ? FSP_ERASED : op_data_q;

    // Read protection: set by protect, cleared by array erase
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            prot_q <= 1'b0;
        end else if (launch && sfr_wdata_i[1:0] == FSP_FN_PROT) begin
            prot_q <= 1'b1;
        end else if (launch && sfr_wdata_i[1:0] == FSP_FN_CHIP) begin
            prot_q <= 1'b0;
        end
    end

    logic [7:0] mem_rdata;
    fsp_flash_mem #(.AW(16)) u_mem (
        .clock_i (clock_i),
        .we_i    (mem_we),
        .waddr_i (mem_waddr),
        .wdata_i (mem_wdata),
        .raddr_i (fetch_addr_i),
        .rdata_o (mem_rdata)
    );

    // Protection applies per read; masks the registered array output
    assign fetch_data_o   = prot_q ? FSP_PROT_READ : mem_rdata;
    assign core_stall_o   = start_q;
    assign read_protect_o = prot_q;

    // ==========================================================
    // SFR read path
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i) begin
            unique case (sfr_addr_i)
                FSP_ADDR_SYSCTL: sfr_rdata_o <= sysctl_q;
                FSP_ADDR_FAH:    sfr_rdata_o <= fah_q;
                FSP_ADDR_FAL:    sfr_rdata_o <= fal_q;
                FSP_ADDR_FDATA:  sfr_rdata_o <= fdata_q;
                FSP_ADDR_FCTRL:  sfr_rdata_o <= {start_q, 5'h00, fsel_q};
                default:         sfr_rdata_o <= 8'h00;
            endcase
        end
    end
    assign sfr_hit_o = sfr_addr_i == FSP_ADDR_SYSCTL
        || (sfr_addr_i >= FSP_ADDR_FAH && sfr_addr_i <= FSP_ADDR_FCTRL);

    // ==========================================================
    // Checks
    chk_enable_reset: assert property (@(posedge clock_i)
        !resetn_i |=> !sysctl_q[FSP_BIT_ENABLE])
        else $error("enable not clear after reset");
    chk_launch_gated: assert property (@(posedge clock_i)
        disable iff (!resetn_i)
        $rose(start_q) |-> $past(sysctl_q[FSP_BIT_ENABLE])
                           && $past(ul_q) == FSP_UL_ARMED)
        else $error("start without unlock or enable");
    chk_addr_sample: assert property (@(posedge clock_i)
        disable iff (!resetn_i)
        launch && sfr_wdata_i[1:0] == FSP_FN_PROG
        |=> op_addr_q == $past({fah_q, fal_q})
            && op_data_q == $past(fdata_q))
        else $error("address or data not sampled");
    // Counts stall cycles, since the runs are far too long to unroll
    logic [CW-1:0] stall_len_q;
    always_ff @(posedge clock_i) begin
        if (!resetn_i || launch) begin
            stall_len_q <= '0;
        end else if (start_q) begin
            stall_len_q <= stall_len_q + CW'(1);
        end
    end

    chk_prog_time: assert property (@(posedge clock_i)
        disable iff (!resetn_i)
        $fell(start_q) && fsel_q == FSP_FN_PROG
        |-> stall_len_q == CW'(PROG_CYCLES))
        else $error("program stall length wrong");
    chk_disarm: assert property (@(posedge clock_i)
        disable iff (!resetn_i)
        launch |=> ul_q == FSP_UL_IDLE)
        else $error("unlock not disarmed");
    chk_wdr_set: assert property (@(posedge clock_i)
        disable iff (!resetn_i)
        wdog_reset_i |=> sysctl_q[FSP_BIT_WDR])
        else $error("watchdog flag not set");
    chk_prot_read: assert property (@(posedge clock_i)
        disable iff (!resetn_i)
        prot_q |-> fetch_data_o == FSP_PROT_READ)
        else $error("protected read leaked");
    chk_chip_unprot: assert property (@(posedge clock_i)
        disable iff (!resetn_i)
        launch && sfr_wdata_i[1:0] == FSP_FN_CHIP |=> !prot_q)
        else $error("array erase kept protection");
    chk_boot_safe: assert property (@(posedge clock_i)
        disable iff (!resetn_i)
        mem_we && erase_on
        |-> 32'(mem_waddr) < (NPAGES - BOOT_PAGES) * 512)
        else $error("boot region erased");
    chk_prog_write: assert property (@(posedge clock_i)
        disable iff (!resetn_i)
        $fell(start_q) && fsel_q == FSP_FN_PROG
        |-> $past(mem_we) && $past(mem_wdata) == op_data_q)
        else $error("byte program missing");

    cov_prog: cover property (@(posedge clock_i)
        launch && sfr_wdata_i[1:0] == FSP_FN_PROG);
    cov_page: cover property (@(posedge clock_i)
        launch && sfr_wdata_i[1:0] == FSP_FN_PAGE);
    cov_prot: cover property (@(posedge clock_i)
        launch && sfr_wdata_i[1:0] == FSP_FN_PROT);
    cov_refused: cover property (@(posedge clock_i)
        wr_ctl && sfr_wdata_i[FSP_BIT_START] && !launch);
    cov_chip: cover property (@(posedge clock_i)
        launch && sfr_wdata_i[1:0] == FSP_FN_CHIP);
endmodule : fsp_ctrl

// *** verification/fsp_core_model.sv ***
// Core-side model: issues SFR transfers the way the user program would.
// Assumes the controller stalls the core while an operation runs.
`timescale 1ns/1ps
module fsp_core_model
    import fsp_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       core_stall_i,
    input  wire logic [7:0] sfr_rdata_i,
    output logic            sfr_wr_o,
    output logic            sfr_rd_o,
    output logic      [7:0] sfr_addr_o,
    output logic      [7:0] sfr_wdata_o
);
    initial begin
        sfr_wr_o    = 1'b0;
        sfr_rd_o    = 1'b0;
        sfr_addr_o  = 8'h00;
        sfr_wdata_o = 8'h00;
    end

    // A frozen program counter issues nothing
    task automatic hold_off();
        int n;
        n = 0;
        while (core_stall_i === 1'b1 && n < 70000) begin
            @(posedge clock_i);
            n++;
        end
        if (n >= 70000) begin
            fsp_ctrl_bench.n_fail++;
            fsp_ctrl_bench.close_out();
        end
    endtask : hold_off

    task automatic write_sfr(input logic [7:0] a, input logic [7:0] d);
        hold_off();
        @(posedge clock_i);
        sfr_wr_o    <= 1'b1;
        sfr_addr_o  <= a;
        sfr_wdata_o <= d;
        @(posedge clock_i);
        sfr_wr_o    <= 1'b0;
        // Released bus never shows the last value
        sfr_addr_o  <= ~a;
        sfr_wdata_o <= ~d;
    endtask : write_sfr

    task automatic read_sfr(input logic [7:0] a, output logic [7:0] d);
        hold_off();
        @(posedge clock_i);
        sfr_rd_o   <= 1'b1;
        sfr_addr_o <= a;
        @(posedge clock_i);
        sfr_rd_o   <= 1'b0;
        sfr_addr_o <= ~a;
        @(posedge clock_i);
        #1 d = sfr_rdata_i;
    endtask : read_sfr

    task automatic unlock();
        write_sfr(FSP_ADDR_FDATA, FSP_UNLOCK_A);
        write_sfr(FSP_ADDR_FDATA, FSP_UNLOCK_B);
        write_sfr(FSP_ADDR_FDATA, FSP_UNLOCK_A);
    endtask : unlock

    // Page erases pass a low byte of 00h by the caller's address
    task automatic launch(input logic [15:0] a, input logic [7:0] d,
                          input fsp_fn_t fn);
        unlock();
        write_sfr(FSP_ADDR_SYSCTL, 8'h04);
        write_sfr(FSP_ADDR_FAH, a[15:8]);
        write_sfr(FSP_ADDR_FAL, a[7:0]);
        write_sfr(FSP_ADDR_FDATA, d);
        write_sfr(FSP_ADDR_FCTRL, {1'b1, 5'h00, fn});
    endtask : launch
endmodule : fsp_core_model

// *** verification/fsp_ctrl_bench.sv ***
// Self-checking bench for the flash self-programming controller.
// Assumes the core model drives the SFR side; program and protect counts shortened by params.
`timescale 1ns/1ps
module fsp_ctrl_bench;
    import fsp_pkg::*;
    localparam int P_PROG = 5;
    localparam int P_PROT = 3;
    localparam logic [7:0] FF = 8'hFF;

    logic        clock_i;
    logic        resetn_i;
    logic        wdog_reset_i;
    logic        sfr_wr;
    logic        sfr_rd;
    logic [7:0]  sfr_addr;
    logic [7:0]  sfr_wdata;
    logic [7:0]  sfr_rdata;
    logic [15:0] fetch_addr;
    logic [7:0]  fetch_data;
    logic        core_stall;
    logic        read_protect;
    logic        sfr_hit;
    int          n_fail;
    int          checks;
    logic [7:0]  v;

    fsp_ctrl #(.PROG_CYCLES(P_PROG), .PROT_CYCLES(P_PROT)) dut_u (
        .clock_i(clock_i), .resetn_i(resetn_i),
        .wdog_reset_i(wdog_reset_i), .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd),
        .sfr_addr_i(sfr_addr), .sfr_wdata_i(sfr_wdata),
        .sfr_rdata_o(sfr_rdata), .sfr_hit_o(sfr_hit),
        .fetch_addr_i(fetch_addr),
        .fetch_data_o(fetch_data), .core_stall_o(core_stall),
        .read_protect_o(read_protect));

    fsp_core_model core_u (
        .clock_i(clock_i), .core_stall_i(core_stall),
        .sfr_rdata_i(sfr_rdata), .sfr_wr_o(sfr_wr), .sfr_rd_o(sfr_rd),
        .sfr_addr_o(sfr_addr), .sfr_wdata_o(sfr_wdata));

    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    task automatic close_out();
        if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
            n_fail++;
        end
    endtask : check

    task automatic fetch(input logic [15:0] a, output logic [7:0] d);
        @(posedge clock_i);
        fetch_addr <= a;
        @(posedge clock_i);
        @(posedge clock_i);
        #1 d = fetch_data;
    endtask : fetch

    // Called right after the launching edge; counts cycles of stall
    task automatic run_len(input int exp);
        int n;
        n = 0;
        #1;
        while (core_stall === 1'b1 && n < 70000) begin
            n++;
            @(posedge clock_i);
            #1;
        end
        if (n >= 70000) begin
            n_fail++;
            close_out();
        end
        check("stall cycles", n, exp);
        core_u.read_sfr(FSP_ADDR_FCTRL, v);
        check("start bit after", v[7], 1'b0);
    endtask : run_len

    task automatic t_reset();
        core_u.read_sfr(FSP_ADDR_SYSCTL, v);
        check("sysctl reset", v, FSP_SYSCTL_RST);
        check("enable reset", v[FSP_BIT_ENABLE], 1'b0);
        for (int a = 'hF4; a <= 'hF7; a++) begin
            core_u.read_sfr(a[7:0], v);
            check("reg reset", v, FSP_REG_RST);
        end
        // Released bus shows the inverse address, here outside the map
        check("hit idle", sfr_hit, 1'b0);
        // Unmapped read gives zero and leaves F4h on the bus
        core_u.read_sfr(8'h0B, v);
        check("unmapped read", v, 8'h00);
        check("hit address high", sfr_hit, 1'b1);
        check("stall reset", core_stall, 1'b0);
        check("protect reset", read_protect, 1'b0);
    endtask : t_reset

    task automatic t_refuse();
        core_u.write_sfr(FSP_ADDR_SYSCTL, 8'h04);
        core_u.write_sfr(FSP_ADDR_FCTRL, 8'h80);
        #1 check("stall no unlock", core_stall, 1'b0);
        core_u.read_sfr(FSP_ADDR_FCTRL, v);
        check("start read only", v[7], 1'b0);
        // Broken order must be tried before arming: armed stays armed
        core_u.write_sfr(FSP_ADDR_FDATA, FSP_UNLOCK_A);
        core_u.write_sfr(FSP_ADDR_FDATA, FSP_UNLOCK_B);
        core_u.write_sfr(FSP_ADDR_FDATA, 8'h33);
        core_u.write_sfr(FSP_ADDR_FDATA, FSP_UNLOCK_A);
        core_u.write_sfr(FSP_ADDR_FCTRL, 8'h80);
        #1 check("stall broken order", core_stall, 1'b0);
        core_u.unlock();
        core_u.write_sfr(FSP_ADDR_SYSCTL, 8'h00);
        core_u.write_sfr(FSP_ADDR_FCTRL, 8'h80);
        #1 check("stall no enable", core_stall, 1'b0);
    endtask : t_refuse

    task automatic t_program();
        core_u.launch(16'h1234, 8'h5A, FSP_FN_PROG);
        run_len(P_PROG);
        fetch(16'h1234, v);
        check("programmed byte", v, 8'h5A);
        core_u.write_sfr(FSP_ADDR_FCTRL, 8'h80);
        #1 check("stall disarmed", core_stall, 1'b0);
        core_u.launch(16'h2200, 8'h11, FSP_FN_PROG);
        run_len(P_PROG);
        core_u.launch(16'h2400, 8'h22, FSP_FN_PROG);
        run_len(P_PROG);
        core_u.launch(16'hFF00, 8'h33, FSP_FN_PROG);
        run_len(P_PROG);
    endtask : t_program

    task automatic t_page();
        core_u.launch(16'h2300, 8'h00, FSP_FN_PAGE);
        run_len(FSP_CYC_PAGE);
        fetch(16'h2200, v);
        check("even half erased", v, FF);
        fetch(16'h2400, v);
        check("next page kept", v, 8'h22);
        fetch(16'h1234, v);
        check("other page kept", v, 8'h5A);
        core_u.launch(16'hFF00, 8'h00, FSP_FN_PAGE);
        run_len(FSP_CYC_PAGE);
        fetch(16'hFF00, v);
        check("boot page kept", v, 8'h33);
    endtask : t_page

    task automatic t_protect();
        core_u.launch(16'h0000, 8'h00, FSP_FN_PROT);
        run_len(P_PROT);
        check("protect on", read_protect, 1'b1);
        fetch(16'h1234, v);
        check("masked read", v, FSP_PROT_READ);
        core_u.launch(16'h0000, 8'h00, FSP_FN_CHIP);
        run_len(FSP_CYC_CHIP);
        check("protect cleared", read_protect, 1'b0);
        fetch(16'h1234, v);
        check("array erased", v, FF);
        fetch(16'hFF00, v);
        check("boot kept", v, 8'h33);
    endtask : t_protect

    task automatic t_wdog();
        @(posedge clock_i);
        wdog_reset_i <= 1'b1;
        @(posedge clock_i);
        wdog_reset_i <= 1'b0;
        core_u.read_sfr(FSP_ADDR_SYSCTL, v);
        check("watchdog flag", v[7], 1'b1);
        core_u.write_sfr(FSP_ADDR_SYSCTL, 8'h00);
        core_u.read_sfr(FSP_ADDR_SYSCTL, v);
        check("watchdog flag clear", v[7], 1'b0);
    endtask : t_wdog

    initial begin
        n_fail       = 0;
        checks       = 0;
        resetn_i     = 1'b0;
        wdog_reset_i = 1'b0;
        fetch_addr   = 16'h0000;
        repeat (12) @(posedge clock_i);
        resetn_i <= 1'b1;
        t_reset();
        t_refuse();
        t_program();
        t_page();
        t_protect();
        t_wdog();
        close_out();
    end
endmodule : fsp_ctrl_bench
